// [include/rbd_pkg.sv]
// Package for the rotate-right and bit-set datapath: map, encodings, types
`default_nettype none
package rbd_pkg;
    // Register byte offsets
    localparam logic [7:0] RBD_CMD_OFS = 8'h00;
    localparam logic [7:0] RBD_OPERAND_OFS = 8'h04;
    localparam logic [7:0] RBD_ACC_OFS = 8'h08;
    localparam logic [7:0] RBD_COUNT_OFS = 8'h0c;
    localparam logic [7:0] RBD_FLAGS_OFS = 8'h10;
    localparam logic [7:0] RBD_STATUS_OFS = 8'h14;
    localparam logic [7:0] RBD_SRC_IDX_OFS = 8'h18;
    localparam logic [7:0] RBD_DST_IDX_OFS = 8'h1c;
    localparam logic [7:0] RBD_STEP_OFS = 8'h20;

    // Reset values
    localparam logic [15:0] RBD_OPERAND_RST = 16'h0000;
    localparam logic [7:0] RBD_ACC_RST = 8'h00;
    localparam logic [7:0] RBD_COUNT_RST = 8'h00;
    localparam logic [15:0] RBD_IDX_RST = 16'h0000;
    localparam logic [6:0] RBD_FLAGS_RST = 7'h00;

    // Field positions
    localparam int RBD_STATUS_BUSY_BIT = 0;
    localparam int RBD_STATUS_BAD_BIT = 1;
    localparam int RBD_STEP_WORD_BIT = 0;
    localparam int RBD_REG_FIELD_LSB = 3;
    localparam int RBD_BYTE_MSB = 7;
    localparam int RBD_WORD_MSB = 15;

    // Opcode encodings
    localparam logic [6:0] RBD_OPC_ROT_ONE = 7'h68;
    localparam logic [6:0] RBD_OPC_ROT_REG = 7'h69;
    localparam logic [6:0] RBD_OPC_ROT_IMM = 7'h60;
    localparam logic [2:0] RBD_RF_ROTATE = 3'h1;
    localparam logic [2:0] RBD_RF_ROTATE_CARRY = 3'h3;
    localparam logic [2:0] RBD_RF_ZERO = 3'h0;
    localparam logic [7:0] RBD_OPC_EXT = 8'h0f;
    localparam logic [7:0] RBD_EXT_NIBBLE = 8'h2a;
    localparam logic [7:0] RBD_EXT_BSET_CNT_B = 8'h14;
    localparam logic [7:0] RBD_EXT_BSET_CNT_W = 8'h15;
    localparam logic [7:0] RBD_EXT_BSET_IMM_B = 8'h1c;
    localparam logic [7:0] RBD_EXT_BSET_IMM_W = 8'h1d;
    localparam logic [7:0] RBD_OPC_SET_CARRY = 8'hf9;
    localparam logic [7:0] RBD_OPC_SET_DIR = 8'hfd;

    // Index masks for the bit-set forms
    localparam logic [3:0] RBD_BYTE_IDX_MASK = 4'h7;
    localparam logic [3:0] RBD_WORD_IDX_MASK = 4'hf;

    // Index register step sizes
    localparam logic [15:0] RBD_STEP_BYTE = 16'h0001;
    localparam logic [15:0] RBD_STEP_WORD = 16'h0002;

    typedef enum logic [2:0] {
        RBD_OP_NONE = 3'h0,
        RBD_OP_ROT = 3'h1,
        RBD_OP_NIB = 3'h2,
        RBD_OP_BSET = 3'h3,
        RBD_OP_SETCY = 3'h4,
        RBD_OP_SETDIR = 3'h5,
        RBD_OP_BAD = 3'h6
    } rbd_op_t;

    typedef enum logic [1:0] {
        RBD_CNT_ONE = 2'h0,
        RBD_CNT_REG = 2'h1,
        RBD_CNT_IMM = 2'h2
    } rbd_cnt_src_t;

    typedef enum logic [1:0] {
        RBD_ST_IDLE = 2'b00,
        RBD_ST_RUN = 2'b01
    } rbd_state_t;

    typedef struct packed {
        logic zero_flag;
        logic sign_flag;
        logic parity_flag;
        logic aux_carry_flag;
        logic overflow_flag;
        logic dir_flag;
        logic carry_flag;
    } rbd_flags_t;

    typedef struct packed {
        logic [15:0] value;
        logic carry;
    } rbd_rot_t;

    typedef struct packed {
        rbd_op_t op;
        logic wide;
        logic thru;
        rbd_cnt_src_t cnt_src;
        logic [7:0] imm;
    } rbd_dec_t;
endpackage : rbd_pkg
`default_nettype wire

// [rtl/rbd_datapath.sv]
// Rotate-right group and bit-set execution datapath with an Avalon-MM slave
//
// Decided for this implementation: the Avalon-MM interface to the registers and the address map.
`default_nettype none
module rbd_datapath
    import rbd_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [7:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    output logic carry_flag_o,
    output logic dir_flag_o,
    output logic busy_o
);

    function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
        begin
            if (be[i])
            begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r;
    endfunction : be_merge

    function automatic logic msb_of(input logic [15:0] v, input logic wide);
        return wide ? v[RBD_WORD_MSB] : v[RBD_BYTE_MSB];
    endfunction : msb_of

    // One position right; the byte form leaves the upper operand byte alone
    function automatic rbd_rot_t rot_step(input logic [15:0] v, input logic wide,
                                          input logic thru, input logic cin);
        rbd_rot_t r;
        logic top;
        top = thru ? cin : v[0];
        r.carry = v[0];
        if (wide)
        begin
            r.value = {top, v[15:1]};
        end
        else
        begin
            r.value = {v[15:8], top, v[7:1]};
        end
        return r;
    endfunction : rot_step

    function automatic rbd_dec_t decode_cmd(input logic [31:0] c);
        rbd_dec_t d;
        logic [7:0] b0;
        logic [7:0] b1;
        logic [7:0] b2;
        logic [7:0] b3;
        b0 = c[7:0];
        b1 = c[15:8];
        b2 = c[23:16];
        b3 = c[31:24];
        d.op = RBD_OP_BAD;
        d.wide = b0[0];
        d.thru = 1'b0;
        d.cnt_src = RBD_CNT_ONE;
        d.imm = b2;
        if (b0[7:1] == RBD_OPC_ROT_ONE || b0[7:1] == RBD_OPC_ROT_REG ||
            b0[7:1] == RBD_OPC_ROT_IMM)
        begin
            if (b0[7:1] == RBD_OPC_ROT_REG)
            begin
                d.cnt_src = RBD_CNT_REG;
            end
            else if (b0[7:1] == RBD_OPC_ROT_IMM)
            begin
                d.cnt_src = RBD_CNT_IMM;
            end
            if (b1[RBD_REG_FIELD_LSB +: 3] == RBD_RF_ROTATE)
            begin
                d.op = RBD_OP_ROT;
            end
            else if (b1[RBD_REG_FIELD_LSB +: 3] == RBD_RF_ROTATE_CARRY)
            begin
                d.op = RBD_OP_ROT;
                d.thru = 1'b1;
            end
        end
        else if (b0 == RBD_OPC_EXT && b2[RBD_REG_FIELD_LSB +: 3] == RBD_RF_ZERO)
        begin
            d.wide = b1[0];
            // The fetch path places the index byte (fourth or last) in b3
            d.imm = b3;
            if (b1 == RBD_EXT_NIBBLE)
            begin
                d.op = RBD_OP_NIB;
                d.wide = 1'b0;
            end
            else if (b1 == RBD_EXT_BSET_CNT_B || b1 == RBD_EXT_BSET_CNT_W)
            begin
                d.op = RBD_OP_BSET;
                d.cnt_src = RBD_CNT_REG;
            end
            else if (b1 == RBD_EXT_BSET_IMM_B || b1 == RBD_EXT_BSET_IMM_W)
            begin
                d.op = RBD_OP_BSET;
                d.cnt_src = RBD_CNT_IMM;
            end
        end
        else if (b0 == RBD_OPC_SET_CARRY)
        begin
            d.op = RBD_OP_SETCY;
        end
        else if (b0 == RBD_OPC_SET_DIR)
        begin
            d.op = RBD_OP_SETDIR;
        end
        return d;
    endfunction : decode_cmd

    rbd_state_t state;
    rbd_state_t next_state;
    rbd_flags_t flags;
    rbd_flags_t next_flags;
    logic [15:0] operand;
    logic [15:0] next_operand;
    logic [7:0] acc;
    logic [7:0] next_acc;
    logic [7:0] count;
    logic [7:0] next_count;
    logic [15:0] src_idx;
    logic [15:0] next_src_idx;
    logic [15:0] dst_idx;
    logic [15:0] next_dst_idx;
    logic [7:0] remain;
    logic [7:0] next_remain;
    logic run_wide;
    logic next_run_wide;
    logic run_thru;
    logic next_run_thru;
    logic bad_cmd;
    logic next_bad_cmd;
    logic ack;
    logic next_ack;
    logic [31:0] rdata;
    logic [31:0] next_rdata;

    logic req;
    logic wr_ok;
    rbd_dec_t dec;
    rbd_rot_t one_rot;
    rbd_rot_t run_rot;
    logic [31:0] wmerge;
    logic [31:0] rd_mux;
    logic [3:0] bit_idx;
    logic [7:0] idx_src;
    logic [15:0] step;

    assign req = avs_read_i | avs_write_i;
    // Answer one cycle after the request; a running rotate stalls every access
    assign avs_waitrequest_o = req & ~ack;
    assign wr_ok = avs_write_i & ack;
    assign avs_readdata_o = rdata;
    assign carry_flag_o = flags.carry_flag;
    assign dir_flag_o = flags.dir_flag;
    assign busy_o = (state == RBD_ST_RUN);

    always_comb
    begin
        rd_mux = 32'h0000_0000;
        case (avs_address_i)
            RBD_OPERAND_OFS: rd_mux = {16'h0000, operand};
            RBD_ACC_OFS: rd_mux = {24'h00_0000, acc};
            RBD_COUNT_OFS: rd_mux = {24'h00_0000, count};
            RBD_FLAGS_OFS: rd_mux = {25'h000_0000, flags};
            RBD_STATUS_OFS: rd_mux = {30'h0000_0000, bad_cmd, busy_o};
            RBD_SRC_IDX_OFS: rd_mux = {16'h0000, src_idx};
            RBD_DST_IDX_OFS: rd_mux = {16'h0000, dst_idx};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    always_comb
    begin
        dec = decode_cmd(avs_writedata_i);
        one_rot = rot_step(operand, dec.wide, dec.thru, flags.carry_flag);
        run_rot = rot_step(operand, run_wide, run_thru, flags.carry_flag);
        idx_src = (dec.cnt_src == RBD_CNT_REG) ? count : dec.imm;
        bit_idx = idx_src[3:0] &
            (dec.wide ? RBD_WORD_IDX_MASK : RBD_BYTE_IDX_MASK);
        // The read mux already holds the addressed register, zero-extended
        wmerge = be_merge(rd_mux, avs_writedata_i, avs_byteenable_i);
        step = RBD_STEP_BYTE;
        next_state = state;
        next_flags = flags;
        next_operand = operand;
        next_acc = acc;
        next_count = count;
        next_src_idx = src_idx;
        next_dst_idx = dst_idx;
        next_remain = remain;
        next_run_wide = run_wide;
        next_run_thru = run_thru;
        next_bad_cmd = bad_cmd;
        next_rdata = rdata;
        next_ack = 1'b0;
        if (req & ~ack & (state == RBD_ST_IDLE))
        begin
            next_ack = 1'b1;
            if (avs_read_i)
            begin
                next_rdata = rd_mux;
            end
        end
        if (state == RBD_ST_RUN)
        begin
            // One position per clock; overflow is left as it was
            next_operand = run_rot.value;
            next_flags.carry_flag = run_rot.carry;
            next_remain = remain - 8'h01;
            if (remain == 8'h01)
            begin
                next_state = RBD_ST_IDLE;
            end
        end
        if (wr_ok)
        begin
            case (avs_address_i)
                RBD_CMD_OFS:
                begin
                    next_bad_cmd = 1'b0;
                    case (dec.op)
                        RBD_OP_ROT:
                        begin
                            if (dec.cnt_src == RBD_CNT_ONE)
                            begin
                                next_operand = one_rot.value;
                                next_flags.carry_flag = one_rot.carry;
                                next_flags.overflow_flag = msb_of(operand, dec.wide) ^
                                    msb_of(one_rot.value, dec.wide);
                            end
                            else if (idx_src != 8'h00)
                            begin
                                next_state = RBD_ST_RUN;
                                next_remain = idx_src;
                                next_run_wide = dec.wide;
                                next_run_thru = dec.thru;
                            end
                        end
                        RBD_OP_NIB:
                        begin
                            // Upper accumulator nibble is kept, though callers may not rely on it
                            next_operand = {operand[15:8], acc[3:0], operand[7:4]};
                            next_acc = {acc[7:4], operand[3:0]};
                        end
                        RBD_OP_BSET:
                        begin
                            next_operand = operand | (16'h0001 << bit_idx);
                        end
                        RBD_OP_SETCY:
                        begin
                            next_flags.carry_flag = 1'b1;
                        end
                        RBD_OP_SETDIR:
                        begin
                            next_flags.dir_flag = 1'b1;
                        end
                        default:
                        begin
                            next_bad_cmd = 1'b1;
                        end
                    endcase
                end
                RBD_OPERAND_OFS: next_operand = wmerge[15:0];
                RBD_ACC_OFS: next_acc = wmerge[7:0];
                RBD_COUNT_OFS: next_count = wmerge[7:0];
                RBD_FLAGS_OFS: next_flags = wmerge[6:0];
                RBD_SRC_IDX_OFS: next_src_idx = wmerge[15:0];
                RBD_DST_IDX_OFS: next_dst_idx = wmerge[15:0];
                RBD_STEP_OFS:
                begin
                    step = avs_writedata_i[RBD_STEP_WORD_BIT] ? RBD_STEP_WORD : RBD_STEP_BYTE;
                    if (flags.dir_flag)
                    begin
                        next_src_idx = src_idx - step;
                        next_dst_idx = dst_idx - step;
                    end
                    else
                    begin
                        next_src_idx = src_idx + step;
                        next_dst_idx = dst_idx + step;
                    end
                end
                default:
                begin
                    next_bad_cmd = bad_cmd;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state <= RBD_ST_IDLE;
            flags <= RBD_FLAGS_RST;
            operand <= RBD_OPERAND_RST;
            acc <= RBD_ACC_RST;
            count <= RBD_COUNT_RST;
            src_idx <= RBD_IDX_RST;
            dst_idx <= RBD_IDX_RST;
            remain <= 8'h00;
            run_wide <= 1'b0;
            run_thru <= 1'b0;
            bad_cmd <= 1'b0;
            ack <= 1'b0;
            rdata <= 32'h0000_0000;
        end
        else
        begin
            state <= next_state;
            flags <= next_flags;
            operand <= next_operand;
            acc <= next_acc;
            count <= next_count;
            src_idx <= next_src_idx;
            dst_idx <= next_dst_idx;
            remain <= next_remain;
            run_wide <= next_run_wide;
            run_thru <= next_run_thru;
            bad_cmd <= next_bad_cmd;
            ack <= next_ack;
            rdata <= next_rdata;
        end
    end

endmodule : rbd_datapath
`default_nettype wire

// [test/rbd_datapath_monitor.sv]
// Port-level checker for the rotate-right and bit-set datapath
`default_nettype none
module rbd_monitor
    import rbd_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [7:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic avs_waitrequest_o,
    input wire logic carry_flag_o,
    input wire logic dir_flag_o,
    input wire logic busy_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);
    logic req;
    logic cmd_wr;
    logic rot_rf;
    assign req = avs_read_i | avs_write_i;
    assign cmd_wr = avs_write_i & ~avs_waitrequest_o & (avs_address_i == RBD_CMD_OFS);
    // Reg field 001 or 011 both have bit 13 clear and bit 11 set
    assign rot_rf = ~avs_writedata_i[13] & avs_writedata_i[11];

    chk_set_carry: assert property (
        cmd_wr && avs_writedata_i[7:0] == RBD_OPC_SET_CARRY |=>
            carry_flag_o && $stable(dir_flag_o))
        else $error("set carry command did not set only carry");
    chk_set_dir: assert property (
        cmd_wr && avs_writedata_i[7:0] == RBD_OPC_SET_DIR |=> dir_flag_o && $stable(carry_flag_o))
        else $error("set direction command did not set only direction");
    chk_ext_keeps_flags: assert property (
        cmd_wr && avs_writedata_i[7:0] == RBD_OPC_EXT |=>
            $stable(carry_flag_o) && $stable(dir_flag_o))
        else $error("nibble rotate or bit set changed a flag");
    chk_imm_five_steps: assert property (
        cmd_wr && avs_writedata_i[7:1] == RBD_OPC_ROT_IMM && rot_rf &&
        avs_writedata_i[23:16] == 8'h05 |=> busy_o [*5] ##1 !busy_o)
        else $error("immediate count five did not run five steps");
    chk_zero_count: assert property (
        cmd_wr && avs_writedata_i[7:1] == RBD_OPC_ROT_IMM && avs_writedata_i[23:16] == 8'h00
        |=> !busy_o && $stable(carry_flag_o))
        else $error("zero count rotate had an effect");
    chk_single_idle: assert property (
        cmd_wr && avs_writedata_i[7:1] == RBD_OPC_ROT_ONE |=> !busy_o)
        else $error("single rotate went busy");
    chk_busy_bound: assert property (
        $rose(busy_o) |-> ##[1:255] !busy_o)
        else $error("counted rotate ran too long");
    chk_busy_stall: assert property (
        busy_o && req |-> avs_waitrequest_o)
        else $error("access answered while busy");
    chk_answer_time: assert property (
        req && !busy_o |-> ##[0:1] !avs_waitrequest_o)
        else $error("idle access not answered in time");
    chk_idle_nowait: assert property (
        !req |-> !avs_waitrequest_o)
        else $error("waitrequest without request");

    cov_set_carry: cover property (cmd_wr && avs_writedata_i[7:0] == RBD_OPC_SET_CARRY);
    cov_busy_end: cover property ($fell(busy_o));
    cov_stall: cover property (busy_o && req);
endmodule : rbd_monitor

bind rbd_datapath rbd_monitor mon (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o),
    .carry_flag_o(carry_flag_o),
    .dir_flag_o(dir_flag_o),
    .busy_o(busy_o)
);
`default_nettype wire

// [test/tb.sv]
// Register-level testbench for the rotate-right and bit-set datapath
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin fail_count++; \
    $display("ERROR %0t: got %h expected %h", $time, a, b); end end
module tb
    import rbd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 0;
    logic rst_n_i = 0;
    logic [7:0] avs_address_i = 8'h00;
    logic avs_read_i = 0;
    logic avs_write_i = 0;
    logic [31:0] avs_writedata_i = 32'h0;
    logic [3:0] avs_byteenable_i = 4'hf;
    logic [31:0] avs_readdata_o;
    logic avs_waitrequest_o;
    logic carry_flag_o;
    logic dir_flag_o;
    logic busy_o;
    int fail_count = 0;
    int n_checks = 0;
    logic [31:0] cmds [9] = '{32'h0000c8d0, 32'h0000c8d1, 32'h0000d8d0, 32'h0000d8d1,
        32'h0000c8d2, 32'h0000d8d3, 32'h0005c8c0, 32'h0005d8c1, 32'h0000c8c0};
    logic [15:0] ops [9] = '{16'hab35, 16'h8001, 16'h12fe, 16'h7ff1, 16'h5a96, 16'hc3a5,
        16'h1234, 16'h8421, 16'hbeef};
    logic [7:0] cnts [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h03, 8'h11, 8'h00, 8'h00, 8'h09};
    logic [31:0] bs [4] = '{32'h00c0140f, 32'h00c0150f, 32'h0ec01c0f, 32'hf9c01d0f};
    logic [15:0] bse [4] = '{16'h2408, 16'h2c00, 16'h2440, 16'h2600};
    logic [7:0] rst_ofs [7] = '{8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c};

    rbd_datapath uut (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i),
        .avs_write_i(avs_write_i),
        .avs_writedata_i(avs_writedata_i),
        .avs_byteenable_i(avs_byteenable_i),
        .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o),
        .carry_flag_o(carry_flag_o),
        .dir_flag_o(dir_flag_o),
        .busy_o(busy_o)
    );

    initial
    begin
        forever #4 clk_i = ~clk_i;
    end

    task automatic end_of_test();
        if (fail_count == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : end_of_test

    // Waitrequest and read data are taken at the rising edge, before that edge's own updates
    task automatic bus(input logic [7:0] a, input logic we, input logic [31:0] wd,
        output logic [31:0] rd);
        int k;
        k = 0;
        avs_address_i <= a;
        avs_write_i <= we;
        avs_read_i <= !we;
        avs_writedata_i <= wd;
        do
        begin
            @(posedge clk_i);
            k++;
        end
        while (avs_waitrequest_o !== 1'b0 && k < 300);
        rd = avs_readdata_o;
        if (k >= 300)
            `CHK(avs_waitrequest_o, 1'b0)
        avs_write_i <= 0;
        avs_read_i <= 0;
        @(posedge clk_i);
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        logic [31:0] x;
        bus(a, 1'b1, v, x);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        bus(a, 1'b0, 32'h0, v);
    endtask : rd

    function automatic logic [16:0] ror_ref(input logic [15:0] v, input logic w,
        input logic t, input logic c, input int n);
        logic b;
        for (int j = 0; j < n; j++)
        begin
            b = v[0];
            if (w)
                v = {t ? c : b, v[15:1]};
            else
                v = {v[15:8], t ? c : b, v[7:1]};
            c = b;
        end
        return {c, v};
    endfunction : ror_ref

    initial
    begin
        logic [31:0] d;
        logic [16:0] e;
        logic cin;
        logic mo;
        int n;
        repeat (20) @(posedge clk_i);
        rst_n_i <= 1;
        @(posedge clk_i);
        foreach (rst_ofs[i])
        begin
            rd(rst_ofs[i], d);
            `CHK(d, 32'h0)
        end
        wr(8'h40, 32'hffffffff);
        rd(8'h40, d);
        `CHK(d, 32'h0)
        foreach (cmds[i])
        begin
            cin = i[0];
            wr(RBD_FLAGS_OFS, 32'h78 | cin);
            wr(RBD_OPERAND_OFS, {16'h0, ops[i]});
            wr(RBD_COUNT_OFS, {24'h0, cnts[i]});
            wr(RBD_CMD_OFS, cmds[i]);
            n = (cmds[i][7:1] == RBD_OPC_ROT_ONE) ? 1 :
                (cmds[i][7:1] == RBD_OPC_ROT_REG) ? int'(cnts[i]) : int'(cmds[i][23:16]);
            e = ror_ref(ops[i], cmds[i][0], cmds[i][12], cin, n);
            mo = cmds[i][0] ? ops[i][15] : ops[i][7];
            rd(RBD_OPERAND_OFS, d);
            `CHK(d, {16'h0, e[15:0]})
            rd(RBD_FLAGS_OFS, d);
            `CHK(d[0], e[16])
            `CHK(d[6:3], 4'hf)
            `CHK(carry_flag_o, e[16])
            if (n == 1)
                `CHK(d[2], mo ^ (cmds[i][0] ? e[15] : e[7]))
            if (n == 0)
                `CHK(d, 32'h78 | cin)
        end
        wr(RBD_FLAGS_OFS, 32'h7d);
        wr(RBD_OPERAND_OFS, 32'h5a24);
        wr(RBD_ACC_OFS, 32'h37);
        wr(RBD_CMD_OFS, 32'h00c02a0f);
        rd(RBD_OPERAND_OFS, d);
        `CHK(d, 32'h5a72)
        rd(RBD_ACC_OFS, d);
        `CHK(d[3:0], 4'h4)
        rd(RBD_FLAGS_OFS, d);
        `CHK(d, 32'h7d)
        wr(RBD_COUNT_OFS, 32'hfb);
        foreach (bs[i])
        begin
            wr(RBD_OPERAND_OFS, 32'h2400);
            wr(RBD_CMD_OFS, bs[i]);
            rd(RBD_OPERAND_OFS, d);
            `CHK(d, {16'h0, bse[i]})
            rd(RBD_FLAGS_OFS, d);
            `CHK(d, 32'h7d)
        end
        wr(RBD_FLAGS_OFS, 32'h0);
        wr(RBD_CMD_OFS, {24'h0, RBD_OPC_SET_CARRY});
        `CHK({carry_flag_o, dir_flag_o}, 2'b10)
        wr(RBD_CMD_OFS, {24'h0, RBD_OPC_SET_DIR});
        rd(RBD_FLAGS_OFS, d);
        `CHK(d, 32'h3)
        wr(RBD_SRC_IDX_OFS, 32'h10);
        wr(RBD_DST_IDX_OFS, 32'h20);
        wr(RBD_STEP_OFS, 32'h1);
        rd(RBD_SRC_IDX_OFS, d);
        `CHK(d, 32'he)
        rd(RBD_DST_IDX_OFS, d);
        `CHK(d, 32'h1e)
        wr(RBD_FLAGS_OFS, 32'h0);
        wr(RBD_STEP_OFS, 32'h0);
        rd(RBD_SRC_IDX_OFS, d);
        `CHK(d, 32'hf)
        // Reg field 000 under a rotate opcode is a left rotate, which is not built
        wr(RBD_CMD_OFS, 32'h0000c0d0);
        rd(RBD_STATUS_OFS, d);
        `CHK(d, 32'h2)
        rd(RBD_OPERAND_OFS, d);
        `CHK(d, 32'h2600)
        wr(RBD_CMD_OFS, {24'h0, RBD_OPC_SET_CARRY});
        rd(RBD_STATUS_OFS, d);
        `CHK(d, 32'h0)
        end_of_test();
    end

    initial
    begin
        repeat (5000) @(posedge clk_i);
        fail_count++;
        end_of_test();
    end
endmodule : tb
`undef CHK
`default_nettype wire
